// >>> common/qbp_pkg.sv
// shared constants for the quad-rate burst-of-four port
package qbp_pkg;
    // organisation x18 is the default build
    localparam int ADDR_W_X8 = 19;
    localparam int ADDR_W_X9 = 19;
    localparam int ADDR_W_X18 = 18;
    localparam int ADDR_W_X36 = 17;
    localparam int MASK_W_X8 = 2; // nibble masks
    localparam int MASK_W_X9 = 1;
    localparam int MASK_W_X18 = 2;
    localparam int MASK_W_X36 = 4;
    localparam int DATA_W_X18 = 18;
    localparam int BURST_LEN = 4;
    localparam int FIFO_DEPTH = 4;
    // impedance recalibration interval in clock cycles
    localparam int IMP_PERIOD_CYC = 1024;
    localparam logic ECHO_POS_RST = 1'h0;
    localparam logic ECHO_NEG_RST = 1'h1;
    localparam logic [1:0] BEAT_LAST = 2'h3;

    typedef enum logic [1:0] {OP_IDLE, OP_RD, OP_WR} qbp_op_t;
    typedef enum logic [2:0] {RD_IDLE, RD_W0, RD_W1, RD_W2, RD_W3} qbp_rd_state_t;
endpackage

// >>> logic/qbp_fifo.sv
// small valid/ready fifo for write beats
`timescale 1ns/10ps
module qbp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;
    wire [PW-1:0] wr_nx = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    wire [PW-1:0] rd_nx = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;

    assign o_ready = (cnt_q != (PW + 1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data = mem_q[rd_q];

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_nx;
            if (pop) rd_q <= rd_nx;
            if (push && !pop) cnt_q <= cnt_q + 1'b1;
            else if (pop && !push) cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// >>> logic/qbp_sram_port.sv
// burst-of-four separate-i/o sram core: request arbitration, bursts, echo clocks
`timescale 1ns/10ps
// Behaviour
// RL1: controller issues reads and writes each at most every other cycle.
// RL2: after an idle cycle a read or a write is accepted.
// RL3: every access moves four words stored as one wide word.
// RL4: second read or write on adjacent cycles is ignored.
// RL5: read and write in same cycle: read wins, write dropped.
// RL6: read select and address latched on primary clock rise.
// RL7: write beats captured on next primary, inverted, primary, inverted rises.
// RL8: only lanes with enabled mask are written.
// RL9: read words appear on inverted, true, inverted, true output clock.
// RL10: both output clocks high selects the primary pair instead.
// RL11: loop disabled: output follows selected clock after a delay.
// RL12: true edge raises positive echo; inverted edge raises negative echo.
// RL13: echo clocks always toggle and are never tristated.
// RL14: read data driven only while burst data is shown.
// RL15: read data starts high impedance after power-up.
// RL16: output impedance recalibrated every 1024 clock cycles.
// RL17: address width 19, 18 or 17 by organisation.
// RL18: mask lines one, two or four; nibble masks on x8.
// RL19: mask low writes the lane, high keeps stored data.
module qbp_sram_port #(
    parameter int ADDR_W = qbp_pkg::ADDR_W_X18,
    parameter int DATA_W = qbp_pkg::DATA_W_X18,
    parameter int MASK_W = qbp_pkg::MASK_W_X18
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_clk_k,
    input wire logic i_clk_k_n,
    input wire logic i_clk_c,
    input wire logic i_clk_c_n,
    input wire logic i_rd_sel_n,
    input wire logic i_wr_sel_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic [MASK_W-1:0] i_byte_mask_n,
    input wire logic i_delay_loop_off_n,
    input wire logic i_impedance_ref_pin,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_rd_data_oe,
    output logic o_returned_strobe_pos,
    output logic o_returned_strobe_neg,
    output logic o_impedance_update,
    output logic o_drive_min_imp
);
    localparam int LANE_W = DATA_W / MASK_W;
    localparam int WIDE_W = DATA_W * qbp_pkg::BURST_LEN;
    localparam int WMASK_W = MASK_W * qbp_pkg::BURST_LEN;
    localparam int IN_W = 7 + ADDR_W + DATA_W + MASK_W;
    localparam int ENT_W = 2 + ADDR_W + MASK_W + DATA_W;
    localparam int IMP_W = $clog2(qbp_pkg::IMP_PERIOD_CYC);

    // ---------------- pin synchronisation ----------------
    // all pins share one latency so data lines up with the clock edge found
    logic [IN_W-1:0] pins_s;
    logic [IN_W-1:0] pins_p;
    qbp_sync #(.WIDTH(IN_W)) u_sync (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_async({i_clk_k, i_clk_k_n, i_clk_c, i_clk_c_n, i_rd_sel_n, i_wr_sel_n,
                  i_delay_loop_off_n, i_addr, i_wr_data, i_byte_mask_n}),
        .o_sync(pins_s),
        .o_prev(pins_p)
    );
    wire [ADDR_W-1:0] addr_s = pins_s[DATA_W+MASK_W +: ADDR_W]; // see RL17
    wire [DATA_W-1:0] wdata_s = pins_s[MASK_W +: DATA_W];
    wire [MASK_W-1:0] mask_s = pins_s[MASK_W-1:0]; // see RL18
    wire k_rise = pins_s[IN_W-1] && !pins_p[IN_W-1];
    wire kn_rise = pins_s[IN_W-2] && !pins_p[IN_W-2];
    wire c_rise = pins_s[IN_W-3] && !pins_p[IN_W-3];
    wire cn_rise = pins_s[IN_W-4] && !pins_p[IN_W-4];
    wire rd_n_s = pins_s[IN_W-5];
    wire wr_n_s = pins_s[IN_W-6];
    wire loop_off_s = !pins_s[IN_W-7];
    // both output clocks parked high: fall back to the primary pair
    wire single_clk = pins_s[IN_W-3] && pins_s[IN_W-4]; // see RL10
    wire sel_true_raw = single_clk ? k_rise : c_rise;
    wire sel_inv_raw = single_clk ? kn_rise : cn_rise;

    // loop bypass adds one clock of propagation to data and echoes
    logic true_dly_q;
    logic inv_dly_q;
    wire sel_true_ev = loop_off_s ? true_dly_q : sel_true_raw; // see RL11
    wire sel_inv_ev = loop_off_s ? inv_dly_q : sel_inv_raw; // see RL11

    // ---------------- request arbitration ----------------
    qbp_pkg::qbp_op_t last_op_q;
    wire rd_req = !rd_n_s;
    wire wr_req = !wr_n_s && rd_n_s; // see RL5
    logic fifo_in_ready;
    wire rd_take = k_rise && rd_req && (last_op_q != qbp_pkg::OP_RD); // see RL4 RL6 RL2
    // a full beat fifo refuses new writes; beats of a burst already under way are dropped while it is full
    wire wr_take = k_rise && wr_req && (last_op_q != qbp_pkg::OP_WR) && fifo_in_ready; // see RL4

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            last_op_q <= qbp_pkg::OP_IDLE;
            true_dly_q <= 1'b0;
            inv_dly_q <= 1'b0;
        end else begin
            true_dly_q <= sel_true_raw;
            inv_dly_q <= sel_inv_raw;
            if (k_rise) begin
                last_op_q <= rd_take ? qbp_pkg::OP_RD :
                             (wr_take ? qbp_pkg::OP_WR : qbp_pkg::OP_IDLE);
            end
        end
    end

    // ---------------- write beat capture ----------------
    logic wr_act_q;
    logic [1:0] wr_beat_q;
    logic [ADDR_W-1:0] wr_addr_q;
    logic wr_next_q;
    logic [ADDR_W-1:0] wr_next_addr_q;
    // even beats on primary rise, odd beats on inverted rise
    wire beat_edge = wr_beat_q[0] ? kn_rise : k_rise;
    wire beat_take = wr_act_q && beat_edge; // see RL7
    wire beat_last = (wr_beat_q == qbp_pkg::BEAT_LAST);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wr_act_q <= 1'b0;
            wr_beat_q <= '0;
            wr_addr_q <= '0;
            wr_next_q <= 1'b0;
            wr_next_addr_q <= '0;
        end else begin
            if (beat_take) wr_beat_q <= wr_beat_q + 1'b1;
            if (beat_take && beat_last) begin
                // a write taken on the beat-two edge starts once this burst ends
                wr_act_q <= wr_next_q;
                wr_addr_q <= wr_next_addr_q;
                wr_next_q <= 1'b0;
            end
            if (wr_take && wr_act_q) begin
                wr_next_q <= 1'b1; // see RL7
                wr_next_addr_q <= addr_s;
            end else if (wr_take) begin
                wr_act_q <= 1'b1;
                wr_addr_q <= addr_s;
            end
        end
    end

    logic fifo_valid;
    logic drain_ready;
    logic [ENT_W-1:0] fifo_out;
    qbp_fifo #(.WIDTH(ENT_W), .DEPTH(qbp_pkg::FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_valid(beat_take),
        .o_ready(fifo_in_ready),
        .i_data({wr_beat_q, wr_addr_q, mask_s, wdata_s}),
        .o_valid(fifo_valid),
        .i_ready(drain_ready),
        .o_data(fifo_out)
    );

    // ---------------- burst assembly and commit ----------------
    logic [WIDE_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [WIDE_W-1:0] asm_data_q;
    logic [WMASK_W-1:0] asm_mask_q;
    logic [ADDR_W-1:0] asm_addr_q;
    logic commit_q;
    wire [1:0] f_beat = fifo_out[ENT_W-1 -: 2];
    wire [ADDR_W-1:0] f_addr = fifo_out[MASK_W+DATA_W +: ADDR_W];
    wire [MASK_W-1:0] f_mask = fifo_out[DATA_W +: MASK_W];
    wire [DATA_W-1:0] f_data = fifo_out[DATA_W-1:0];
    // commit cycle stalls the drain so the fifo can really back up
    assign drain_ready = !commit_q;
    wire pop = fifo_valid && drain_ready;
    wire [WIDE_W-1:0] old_word = mem[asm_addr_q];
    logic [WIDE_W-1:0] merged;

    genvar gl;
    generate
        for (gl = 0; gl < WMASK_W; gl++) begin : g_lane
            // a high mask keeps what is stored
            assign merged[gl*LANE_W +: LANE_W] = asm_mask_q[gl] ?
                old_word[gl*LANE_W +: LANE_W] : asm_data_q[gl*LANE_W +: LANE_W]; // see RL8 RL19
        end
    endgenerate

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            asm_data_q <= '0;
            asm_mask_q <= '1;
            asm_addr_q <= '0;
            commit_q <= 1'b0;
        end else begin
            commit_q <= pop && (f_beat == qbp_pkg::BEAT_LAST);
            if (pop) begin
                // beat n lands in word n of the wide entry
                asm_data_q[f_beat*DATA_W +: DATA_W] <= f_data; // see RL3
                asm_mask_q[f_beat*MASK_W +: MASK_W] <= f_mask;
                asm_addr_q <= f_addr;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (commit_q) begin
            mem[asm_addr_q] <= merged; // see RL3
        end
    end

    // ---------------- read path ----------------
    // no forwarding: a read racing an uncommitted write to the same burst sees old data
    qbp_pkg::qbp_rd_state_t rd_state_q;
    qbp_pkg::qbp_rd_state_t rd_state_d;
    logic rd_pend_q;
    logic [WIDE_W-1:0] rd_buf_q;
    logic [WIDE_W-1:0] rd_out_q;
    logic [DATA_W-1:0] rd_data_q;
    wire rd_ends = (rd_state_q == qbp_pkg::RD_IDLE) || (rd_state_q == qbp_pkg::RD_W3);
    wire rd_load = sel_inv_ev && rd_pend_q && rd_ends;

    always_comb begin
        rd_state_d = rd_state_q;
        unique case (rd_state_q)
            qbp_pkg::RD_IDLE: if (rd_load) rd_state_d = qbp_pkg::RD_W0;
            qbp_pkg::RD_W0: if (sel_true_ev) rd_state_d = qbp_pkg::RD_W1;
            qbp_pkg::RD_W1: if (sel_inv_ev) rd_state_d = qbp_pkg::RD_W2;
            qbp_pkg::RD_W2: if (sel_true_ev) rd_state_d = qbp_pkg::RD_W3;
            qbp_pkg::RD_W3: begin
                if (rd_load) rd_state_d = qbp_pkg::RD_W0;
                else if (sel_inv_ev) rd_state_d = qbp_pkg::RD_IDLE;
            end
            default: rd_state_d = qbp_pkg::RD_IDLE;
        endcase
    end

    wire [1:0] word_sel = (rd_state_d == qbp_pkg::RD_W1) ? 2'h1 :
                          (rd_state_d == qbp_pkg::RD_W2) ? 2'h2 :
                          (rd_state_d == qbp_pkg::RD_W3) ? 2'h3 : 2'h0;
    wire [WIDE_W-1:0] word_src = rd_load ? rd_buf_q : rd_out_q;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rd_state_q <= qbp_pkg::RD_IDLE; // see RL15
            rd_pend_q <= 1'b0;
            rd_buf_q <= '0;
            rd_out_q <= '0;
            rd_data_q <= '0;
        end else begin
            rd_state_q <= rd_state_d;
            rd_pend_q <= rd_take || (rd_pend_q && !rd_load);
            if (rd_take) rd_buf_q <= mem[addr_s]; // see RL6
            if (rd_load) rd_out_q <= rd_buf_q;
            rd_data_q <= word_src[word_sel*DATA_W +: DATA_W]; // see RL9
        end
    end

    assign o_rd_data = rd_data_q;
    assign o_rd_data_oe = (rd_state_q != qbp_pkg::RD_IDLE); // see RL14

    // ---------------- echo clocks ----------------
    logic echo_pos_q;
    logic echo_neg_q;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            echo_pos_q <= qbp_pkg::ECHO_POS_RST;
            echo_neg_q <= qbp_pkg::ECHO_NEG_RST;
        end else if (sel_true_ev) begin
            echo_pos_q <= 1'b1; // see RL12 RL13
            echo_neg_q <= 1'b0;
        end else if (sel_inv_ev) begin
            echo_pos_q <= 1'b0; // see RL12 RL13
            echo_neg_q <= 1'b1;
        end
    end
    assign o_returned_strobe_pos = echo_pos_q;
    assign o_returned_strobe_neg = echo_neg_q;

    // ---------------- impedance recalibration ----------------
    logic [IMP_W-1:0] imp_cnt_q;
    logic imp_upd_q;
    logic zq_meta_q;
    logic zq_sync_q;
    logic min_imp_q;
    wire imp_wrap = (imp_cnt_q == IMP_W'(qbp_pkg::IMP_PERIOD_CYC - 1));
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            imp_cnt_q <= '0;
            imp_upd_q <= 1'b0;
            zq_meta_q <= 1'b0;
            zq_sync_q <= 1'b0;
            min_imp_q <= 1'b0;
        end else begin
            zq_meta_q <= i_impedance_ref_pin;
            zq_sync_q <= zq_meta_q;
            imp_cnt_q <= imp_wrap ? '0 : imp_cnt_q + 1'b1;
            imp_upd_q <= imp_wrap; // see RL16
            // reference tied high asks for the lowest drive impedance
            if (imp_wrap) min_imp_q <= zq_sync_q;
        end
    end
    assign o_impedance_update = imp_upd_q;
    assign o_drive_min_imp = min_imp_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence s_word1;
        sel_inv_ev && rd_state_q == qbp_pkg::RD_W1;
    endsequence
    sequence s_word2_shown;
        rd_state_q == qbp_pkg::RD_W2 && o_rd_data_oe;
    endsequence

    chk_read_over_write: assert property ( // see RL5
        k_rise && !rd_n_s && !wr_n_s |-> !wr_take ##1 last_op_q != qbp_pkg::OP_WR)
        else $error("write taken while read also requested");
    chk_idle_then_read: assert property ( // see RL2
        k_rise && last_op_q == qbp_pkg::OP_IDLE && !rd_n_s |-> rd_take)
        else $error("read after idle cycle not accepted");
    chk_second_read_drop: assert property ( // see RL4
        k_rise && last_op_q == qbp_pkg::OP_RD |=> !rd_pend_q || $stable(rd_buf_q))
        else $error("adjacent read was not ignored");
    chk_word_order: assert property ( // see RL9
        s_word1 |=> s_word2_shown)
        else $error("third read word not on inverted edge");
    chk_oe_burst_only: assert property ( // see RL14
        $rose(o_rd_data_oe) |-> $past(sel_inv_ev) && $past(rd_pend_q))
        else $error("read outputs enabled without a burst");
    chk_echo_true_edge: assert property ( // see RL12
        sel_true_ev |=> o_returned_strobe_pos && !o_returned_strobe_neg)
        else $error("true edge did not raise positive echo");
    chk_echo_never_same: assert property ( // see RL13
        o_returned_strobe_pos != o_returned_strobe_neg)
        else $error("echo clocks not complementary");
    chk_imp_period: assert property ( // see RL16
        o_impedance_update |=> !o_impedance_update [*8] ##1 imp_cnt_q == IMP_W'(9))
        else $error("impedance update spacing wrong");
    chk_write_beats: assert property ( // see RL7
        wr_take && !beat_take |=> wr_act_q && wr_beat_q == 2'h0 && wr_addr_q == $past(addr_s))
        else $error("write address not latched for beat zero");
endmodule

// >>> logic/qbp_sync.sv
// two-flop synchroniser for a bundle of pins, with a third stage for edge finding
`timescale 1ns/10ps
module qbp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync,
    output logic [WIDTH-1:0] o_prev
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    // meta_q feeds sync_q only
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
            // prev starts high, but sync_q starts low, so pins that idle high still show one false edge after reset
            prev_q <= '1;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign o_sync = sync_q;
    assign o_prev = prev_q;
endmodule

// >>> sim/qbp_ctrl_model.sv
// memory controller model: link clocks, requests, write beats and read capture
`timescale 1ns/10ps
module qbp_ctrl_model #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 18,
    parameter int MASK_W = 2
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_single,
    input wire logic [DATA_W-1:0] i_rd_data,
    input wire logic i_rd_data_oe,
    input wire logic i_strobe_pos,
    output logic o_clk_k,
    output logic o_clk_k_n,
    output logic o_clk_c,
    output logic o_clk_c_n,
    output logic o_rd_sel_n,
    output logic o_wr_sel_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_wr_data,
    output logic [MASK_W-1:0] o_byte_mask_n
);
    typedef struct {
        logic rd;
        logic wr;
        logic beats;
        logic [ADDR_W-1:0] addr;
        logic [4*DATA_W-1:0] data;
        logic [4*MASK_W-1:0] mask;
    } qbp_cmd_t;
    qbp_cmd_t cmd_q[$];
    logic [DATA_W+MASK_W:0] beat_q[$];
    logic [DATA_W-1:0] got_q[$];
    logic strobe_last;

    // both output clock pins high selects the primary pair
    assign o_clk_c = i_single ? 1'h1 : o_clk_k;
    assign o_clk_c_n = i_single ? 1'h1 : o_clk_k_n;

    task automatic send(input logic rd, input logic wr, input logic beats,
            input logic [ADDR_W-1:0] addr, input logic [4*DATA_W-1:0] data,
            input logic [4*MASK_W-1:0] mask);
        qbp_cmd_t c;
        c = '{rd, wr, beats, addr, data, mask};
        cmd_q.push_back(c);
    endtask

    // beat order k, k_n, k, k_n; between beats the lines show the inverse
    task automatic next_beat();
        logic [DATA_W+MASK_W:0] b;
        b = (beat_q.size() > 0) ? beat_q.pop_front() : '0;
        if (b[DATA_W+MASK_W]) begin
            {o_wr_data, o_byte_mask_n} = b[DATA_W+MASK_W-1:0];
        end else begin
            {o_wr_data, o_byte_mask_n} = ~{o_wr_data, o_byte_mask_n};
        end
    endtask

    // one request slot per k period, changed mid-way between a k_n rise and the next k rise
    task automatic next_cmd();
        qbp_cmd_t c;
        if (cmd_q.size() > 0) c = cmd_q.pop_front();
        else c = '{default: '0};
        o_rd_sel_n = ~c.rd;
        o_wr_sel_n = ~c.wr;
        o_addr = (c.rd | c.wr) ? c.addr : ~o_addr;
        if (c.beats) begin
            // beat0 waits one k period after the address when nothing is queued
            if (beat_q.size() == 0) beat_q.push_back('0);
            for (int n = 0; n < 4; n++) begin
                beat_q.push_back({1'h1, c.data[n*DATA_W +: DATA_W], c.mask[n*MASK_W +: MASK_W]});
            end
        end
    endtask

    initial begin
        o_clk_k = 1'h0;
        o_clk_k_n = 1'h1;
        o_rd_sel_n = 1'h1;
        o_wr_sel_n = 1'h1;
        o_addr = '0;
        o_wr_data = '0;
        o_byte_mask_n = '1;
        @(negedge i_rst);
        #213;
        forever begin
            o_clk_k = 1'h1;
            o_clk_k_n = 1'h0;
            #80;
            next_beat();
            #80;
            o_clk_k = 1'h0;
            o_clk_k_n = 1'h1;
            #80;
            next_beat();
            next_cmd();
            #80;
        end
    end

    // a word is taken at each echo edge while the outputs are driven
    always @(posedge i_mclk) begin
        if (i_rd_data_oe === 1'h1 && i_strobe_pos !== strobe_last) got_q.push_back(i_rd_data);
        strobe_last <= i_strobe_pos;
    end
endmodule

// >>> sim/quad_rate_burst4_sram_port_tb_top.sv
// testbench for the burst-of-four sram port against a controller model
`timescale 1ns/10ps
module quad_rate_burst4_sram_port_tb_top;
    localparam int AW = qbp_pkg::ADDR_W_X18;
    localparam int DW = qbp_pkg::DATA_W_X18;
    localparam int MW = qbp_pkg::MASK_W_X18;
    localparam int WW = qbp_pkg::BURST_LEN * DW;
    localparam int LW = DW / MW;
    logic mclk, rst, single, loop_off_n, imp_ref;
    logic k, k_n, c, c_n, rd_n, wr_n, oe, pos, neg, imp_upd, min_imp;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata, rdata;
    logic [MW-1:0] mask_n;
    int failures, n_checks, cyc, last_upd, n_upd, since;
    logic [WW-1:0] mem [logic [AW-1:0]];
    logic [WW-1:0] exp_q[$];

    qbp_sram_port qbp_sram_port_i (.i_mclk(mclk), .i_rst(rst), .i_clk_k(k), .i_clk_k_n(k_n),
        .i_clk_c(c), .i_clk_c_n(c_n), .i_rd_sel_n(rd_n), .i_wr_sel_n(wr_n), .i_addr(addr),
        .i_wr_data(wdata), .i_byte_mask_n(mask_n), .i_delay_loop_off_n(loop_off_n),
        .i_impedance_ref_pin(imp_ref), .o_rd_data(rdata), .o_rd_data_oe(oe),
        .o_returned_strobe_pos(pos), .o_returned_strobe_neg(neg),
        .o_impedance_update(imp_upd), .o_drive_min_imp(min_imp));
    qbp_ctrl_model #(.ADDR_W(AW), .DATA_W(DW), .MASK_W(MW)) qbp_ctrl_model_i (
        .i_mclk(mclk), .i_rst(rst), .i_single(single), .i_rd_data(rdata),
        .i_rd_data_oe(oe), .i_strobe_pos(pos), .o_clk_k(k), .o_clk_k_n(k_n), .o_clk_c(c),
        .o_clk_c_n(c_n), .o_rd_sel_n(rd_n), .o_wr_sel_n(wr_n), .o_addr(addr),
        .o_wr_data(wdata), .o_byte_mask_n(mask_n));

    task automatic check(input string what, input logic [WW-1:0] exp, input logic [WW-1:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [WW-1:0] rnd();
        logic [95:0] t;
        t = {$urandom, $urandom, $urandom};
        return t[WW-1:0];
    endfunction

    // masked-off lanes keep the stored value
    function automatic logic [WW-1:0] merge(input logic [WW-1:0] old, input logic [WW-1:0] d,
            input logic [4*MW-1:0] m);
        logic [WW-1:0] r;
        r = old;
        for (int n = 0; n < 4; n++)
            for (int i = 0; i < MW; i++)
                if (!m[n*MW+i]) r[n*DW+i*LW +: LW] = d[n*DW+i*LW +: LW];
        return r;
    endfunction

    task automatic wr(input logic [AW-1:0] a, input logic [WW-1:0] d,
            input logic [4*MW-1:0] m, input logic taken);
        qbp_ctrl_model_i.send(1'h0, 1'h1, taken, a, d, m);
        if (taken) mem[a] = merge(mem.exists(a) ? mem[a] : '0, d, m);
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic taken);
        qbp_ctrl_model_i.send(1'h1, 1'h0, 1'h0, a, '0, '0);
        if (taken) exp_q.push_back(mem[a]);
    endtask

    task automatic idle();
        qbp_ctrl_model_i.send(1'h0, 1'h0, 1'h0, '0, '0, '0);
    endtask

    task automatic flush();
        logic [WW-1:0] w;
        int guard;
        guard = 0;
        while (qbp_ctrl_model_i.cmd_q.size() + qbp_ctrl_model_i.beat_q.size() > 0
                && guard < 5000) begin
            @(posedge mclk);
            guard++;
        end
        check("flush drained", 1'h1, guard < 5000);
        repeat (40) @(posedge mclk);
        check("idle oe", 1'h0, oe);
        check("word count", 4 * exp_q.size(), qbp_ctrl_model_i.got_q.size());
        while (exp_q.size() > 0 && qbp_ctrl_model_i.got_q.size() >= 4) begin
            w = exp_q.pop_front();
            for (int n = 0; n < 4; n++) begin
                check("read word", w[n*DW +: DW], qbp_ctrl_model_i.got_q.pop_front());
            end
        end
        exp_q.delete();
        qbp_ctrl_model_i.got_q.delete();
    endtask

    task automatic echo_check();
        int n;
        logic p;
        n = 0;
        p = pos;
        repeat (64) begin
            @(posedge mclk);
            check("echo pair", 1'h1, pos ^ neg);
            if (pos !== p) n++;
            p = pos;
        end
        // one true and one inverted edge per 8 mclk
        check("echo toggles", 1'h1, n >= 15 && n <= 17);
    endtask

    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        since++;
        if (rst === 1'h0 && imp_upd === 1'h1) begin
            if (n_upd > 0) check("update interval", qbp_pkg::IMP_PERIOD_CYC, cyc - last_upd);
            n_upd++;
            last_upd = cyc;
            since = 0;
        end
        if (since == 4) begin
            check("min impedance", imp_ref, min_imp);
            // ref pin only moves right after an update, so it is stable at the next one
            #1 imp_ref = 1'($urandom);
        end
    end

    initial begin
        #400000;
        failures++;
        report_and_stop();
    end

    initial begin
        logic [AW-1:0] b;
        failures = 0;
        n_checks = 0;
        n_upd = 0;
        since = 10;
        cyc = 0;
        rst = 1'h1;
        single = 1'h0;
        loop_off_n = 1'h1;
        imp_ref = 1'h0;
        b = AW'($urandom(32'hc59cb6cb));
        repeat (8) @(posedge mclk);
        check("reset oe", 1'h0, oe);
        #1 rst = 1'h0;
        for (int i = 0; i < 8; i++) begin
            wr(b + AW'(i), rnd(), 8'h00, 1'h1);
            idle();
        end
        for (int i = 0; i < 8; i++) begin
            rd(b + AW'(i), 1'h1);
            wr(b + AW'(i + 8), rnd(), 8'h00, 1'h1);
        end
        flush();
        // one burst with every lane off, one with word1 off
        for (int i = 0; i < 8; i++) begin
            wr(b + AW'(i), rnd(), i == 0 ? 8'hff : i == 1 ? 8'h0c : 8'($urandom), 1'h1);
            idle();
        end
        for (int i = 0; i < 16; i++) begin
            rd(b + AW'(i), 1'h1);
            idle();
        end
        flush();
        rd(b, 1'h1);
        rd(b + AW'(1), 1'h0);
        idle();
        wr(b + AW'(2), rnd(), 8'h00, 1'h1);
        wr(b + AW'(3), rnd(), 8'h00, 1'h0);
        idle();
        qbp_ctrl_model_i.send(1'h1, 1'h1, 1'h0, b + AW'(4), rnd(), 8'h00);
        exp_q.push_back(mem[b + AW'(4)]);
        idle();
        idle();
        rd(b + AW'(3), 1'h1);
        idle();
        rd(b + AW'(4), 1'h1);
        idle();
        rd(b + AW'(2), 1'h1);
        flush();
        // normal, loop bypass, then single clock mode
        for (int m = 0; m < 3; m++) begin
            @(posedge mclk);
            #1;
            loop_off_n = (m != 1);
            single = (m == 2);
            repeat (32) @(posedge mclk);
            echo_check();
            for (int i = 0; i < 4; i++) begin
                wr(b + AW'(20 + i), rnd(), 8'h00, 1'h1);
                rd(b + AW'(i + 4 * m), 1'h1);
            end
            flush();
        end
        repeat (3200) @(posedge mclk);
        check("update pulses", 1'h1, n_upd >= 3);
        report_and_stop();
    end
endmodule
